// file: hdl/rspm_pkg.sv
// Constants for the reset source and power mode controller.
// Assumes a 32-bit classic Wishbone slave with word-aligned registers.
package rspm_pkg;
   // ----------------------------------------------------------------
   // Register byte offsets
   // ----------------------------------------------------------------
   localparam logic [7:0] RSPM_OFS_FLAGS = 8'h00;
   localparam logic [7:0] RSPM_OFS_CFG = 8'h04;
   localparam logic [7:0] RSPM_OFS_PMODE = 8'h08;
   localparam logic [7:0] RSPM_OFS_REG = 8'h0C;
   localparam logic [7:0] RSPM_OFS_BOOT = 8'h10;
   localparam logic [7:0] RSPM_OFS_SWRST = 8'h14;
   // ----------------------------------------------------------------
   // Reset source flag positions
   // ----------------------------------------------------------------
   localparam int RSPM_F_PIN = 0;
   localparam int RSPM_F_POWER_ON = 1;
   localparam int RSPM_F_BROWNOUT = 2;
   localparam int RSPM_F_WDOG = 3;
   localparam int RSPM_F_SOFT = 4;
   localparam int RSPM_F_BREAK = 5;
   localparam int RSPM_NSRC = 6;
   // ----------------------------------------------------------------
   // Field positions and reset values
   // ----------------------------------------------------------------
   localparam int RSPM_B_PIN_EN = 0;
   localparam int RSPM_B_LOWCUR = 0;
   localparam int RSPM_B_HSRDY = 1;
   localparam int RSPM_B_BOOT_STATUS0 = 0;
   localparam logic [7:0] RSPM_BOOT_VEC_RST = 8'h1F;
   localparam logic [7:0] RSPM_VEC_LOW = 8'h00;
   localparam logic [15:0] RSPM_VEC_ZERO = 16'h0000;
   localparam logic [RSPM_NSRC-1:0] RSPM_FLAGS_POR = 6'h06;
   localparam logic [31:0] RSPM_SWRST_KEY = 32'h0000_00A5;
   // ----------------------------------------------------------------
   // Timing: regulator settle time and reset stretch
   // ----------------------------------------------------------------
   localparam int RSPM_CLK_MHZ = 25;
   localparam int RSPM_HS_SETTLE_NS = 2000;
   localparam int RSPM_HS_CYC = (RSPM_HS_SETTLE_NS * RSPM_CLK_MHZ + 999)
      / 1000;
   localparam int RSPM_RST_STRETCH_CYC = 16;
   // Power modes
   typedef enum logic [1:0] {
      RSPM_RUN, RSPM_IDLE, RSPM_PD, RSPM_TPD
   } rspm_mode_t;
endpackage

// file: hdl/rspm_regu.sv
// Regulator mode switch with high-speed ready handshake.
// Assumes low_sel_i comes from a register in the same clock domain.
`timescale 1ns/10ps
module rspm_regu (
   input wire logic mclk_i,
   input wire logic nrst_i,
   input wire logic por_i,
   input wire logic low_sel_i,
   output logic hs_ready_o
);
   import rspm_pkg::*;
   logic [7:0] cnt;
   logic [7:0] next_cnt;
   logic next_ready;
   // Settle counter runs only while heading back to high speed
   assign next_cnt = low_sel_i ? 8'(RSPM_HS_CYC)
      : (cnt != 8'h00 ? cnt - 8'h01 : 8'h00);
   assign next_ready = !low_sel_i && (cnt == 8'h00);
   always_ff @(posedge mclk_i) begin
      if (!nrst_i || por_i) begin
         cnt <= 8'h00;
         hs_ready_o <= 1'b1;
      end else begin
         cnt <= next_cnt;
         hs_ready_o <= next_ready;
      end
   end
   hs_wait_a: assert property (
      @(posedge mclk_i) disable iff (!nrst_i || por_i)
      $fell(low_sel_i) |-> !hs_ready_o [*8])
      else $error("high speed ready came too early");
endmodule

// file: hdl/rspm_top.sv
// Reset source gathering, reset flags, boot vector and power modes.
// Assumes all inputs synchronous to mclk_i; nrst_i is chip power-on.
//
// Summary of operation
// - power-on detect holds the device in full reset; power_up_i here keeps reset_pin_enable, boot_vec and boot_status_byte0
// - power-on flag sets at power-up, stays until software clears
// - six reset sources: pin, power-on, brownout, watchdog, soft, break
// - each source has its own readable flag, several may be set
// - writing 0 to a flag bit clears that flag
// - power-on reset sets power-on and brownout flags, clears others
// - watchdog reset behaves like power-on for the flags
// - other resets set own flag and keep uncleared flags
// - reset pin enable 1 makes shared pin an active-low reset
// - during power-up the pin always resets; nothing else overrides
// - fetch address is zero or boot vector high byte, 00 low
// - boot address after break, boot status bit 0, or forced programming
// - idle keeps peripherals, leaves on enabled interrupt or reset
// - power-down stops oscillator, brownout off, exits on reset/wake
// - RC oscillator off in power-down unless system clock and RTC
// - total power-down also disables comparators and RC oscillator
// - regulators high speed after power-on
// - clear low-current select then poll high-speed ready
//
// Our own choices: the register offsets and register access over Wishbone.
`timescale 1ns/10ps
module rspm_top (
   input wire logic mclk_i,
   input wire logic nrst_i,
   // Wishbone classic slave
   input wire logic wb_cyc_i,
   input wire logic wb_stb_i,
   input wire logic wb_we_i,
   input wire logic [7:0] wb_adr_i,
   input wire logic [3:0] wb_sel_i,
   input wire logic [31:0] wb_dat_i,
   output logic [31:0] wb_dat_o,
   output logic wb_ack_o,
   // Reset sources, boot force, wake and clock status inputs
   input wire logic power_up_i,
   input wire logic shared_reset_pin_i,
   input wire logic brownout_i,
   input wire logic wdog_rst_i,
   input wire logic break_rst_i,
   input wire logic prog_force_i,
   input wire logic wake_irq_i,
   input wire logic pd_wake_i,
   input wire logic rc_is_sysclk_i,
   input wire logic rtc_en_i,
   // Outputs
   output logic core_rst_o,
   output logic [15:0] fetch_addr_o,
   output logic pin_gpio_o,
   output logic periph_run_o,
   output logic osc_run_o,
   output logic rc_osc_run_o,
   output logic brownout_en_o,
   output logic comp_en_o,
   output logic low_current_o,
   output rspm_pkg::rspm_mode_t mode_o
);
   import rspm_pkg::*;

   // ----------------------------------------------------------------
   // Registers
   // ----------------------------------------------------------------
   logic [RSPM_NSRC-1:0] flags;
   logic reset_pin_enable;
   logic low_current_select;
   logic [7:0] boot_vec;
   logic boot_status_byte0;
   logic [4:0] stretch;
   logic soft_req;
   logic hs_ready;
   logic boot_pick;
   rspm_mode_t mode;

   // ----------------------------------------------------------------
   // Bus decode
   // ----------------------------------------------------------------
   wire bus_req = wb_cyc_i && wb_stb_i && !wb_ack_o;
   wire wr = bus_req && wb_we_i && wb_sel_i[0];
   wire wr_flags = wr && wb_adr_i == RSPM_OFS_FLAGS;
   wire wr_cfg = wr && wb_adr_i == RSPM_OFS_CFG;
   wire wr_mode = wr && wb_adr_i == RSPM_OFS_PMODE;
   wire wr_reg = wr && wb_adr_i == RSPM_OFS_REG;
   wire wr_boot = wr && wb_adr_i == RSPM_OFS_BOOT;
   wire wr_soft = bus_req && wb_we_i && wb_sel_i == 4'hF
      && wb_adr_i == RSPM_OFS_SWRST && wb_dat_i == RSPM_SWRST_KEY;

   // ----------------------------------------------------------------
   // Reset source gathering
   // ----------------------------------------------------------------
   // power-on detect resets
   wire por = !nrst_i || power_up_i;
   wire pin_rst = !shared_reset_pin_i && (reset_pin_enable || power_up_i);
   // Brownout detection is gated off in the deep modes
   wire bo_rst = brownout_i && brownout_en_o;
   wire any_rst = por || pin_rst || bo_rst || wdog_rst_i || soft_req
      || break_rst_i;
   wire por_like = por || wdog_rst_i;

   // Flag set vector for warm resets
   wire [RSPM_NSRC-1:0] warm_set = {break_rst_i, soft_req, wdog_rst_i,
      bo_rst, 1'b0, pin_rst};
   wire [RSPM_NSRC-1:0] keep_mask = wr_flags ? wb_dat_i[RSPM_NSRC-1:0]
      : {RSPM_NSRC{1'b1}};
   wire [RSPM_NSRC-1:0] next_flags = (flags & keep_mask) | warm_set;

   always_ff @(posedge mclk_i) begin
      if (!nrst_i) begin
         flags <= RSPM_FLAGS_POR;
      end else if (por_like) begin
         flags <= RSPM_FLAGS_POR;
      end else begin
         flags <= next_flags;
      end
   end

   // Reset stretch keeps the core down a fixed time after a source goes
   always_ff @(posedge mclk_i) begin
      if (!nrst_i) begin
         stretch <= 5'(RSPM_RST_STRETCH_CYC);
      end else if (any_rst) begin
         stretch <= 5'(RSPM_RST_STRETCH_CYC);
      end else if (stretch != 5'h00) begin
         stretch <= stretch - 5'h01;
      end
   end

   // Software reset is a one-cycle request
   always_ff @(posedge mclk_i) begin
      if (!nrst_i) begin
         soft_req <= 1'b0;
      end else begin
         soft_req <= wr_soft;
      end
   end

   // Core reset follows any source or the stretch
   always_ff @(posedge mclk_i) begin
      if (!nrst_i) begin
         core_rst_o <= 1'b1;
      end else begin
         core_rst_o <= any_rst || stretch != 5'h00;
      end
   end

   // ----------------------------------------------------------------
   // Configuration registers
   // ----------------------------------------------------------------
   // Config bits survive warm resets and power_up_i; only nrst_i restores them
   always_ff @(posedge mclk_i) begin
      if (!nrst_i) begin
         reset_pin_enable <= 1'b0;
         boot_vec <= RSPM_BOOT_VEC_RST;
         boot_status_byte0 <= 1'b0;
      end else begin
         if (wr_cfg) begin
            reset_pin_enable <= wb_dat_i[RSPM_B_PIN_EN];
         end
         if (wr_boot) begin
            boot_status_byte0 <= wb_dat_i[RSPM_B_BOOT_STATUS0];
            boot_vec <= wb_dat_i[15:8];
         end
      end
   end

   // low current only in run or idle
   always_ff @(posedge mclk_i) begin
      if (!nrst_i || por) begin
         low_current_select <= 1'b0;
      end else if (wr_reg) begin
         low_current_select <= wb_dat_i[RSPM_B_LOWCUR];
      end
   end

   rspm_regu u_regu (
      .mclk_i(mclk_i),
      .nrst_i(nrst_i),
      .por_i(por),
      .low_sel_i(low_current_select),
      .hs_ready_o(hs_ready)
   );

   // ----------------------------------------------------------------
   // Boot vector choice
   // ----------------------------------------------------------------
   // boot address conditions
   assign boot_pick = break_rst_i || boot_status_byte0
      || (power_up_i && prog_force_i);
   always_ff @(posedge mclk_i) begin
      if (!nrst_i) begin
         fetch_addr_o <= RSPM_VEC_ZERO;
      end else if (any_rst) begin
         fetch_addr_o <= boot_pick ? {boot_vec, RSPM_VEC_LOW}
            : RSPM_VEC_ZERO;
      end
   end

   // ----------------------------------------------------------------
   // Power modes
   // ----------------------------------------------------------------
   wire [1:0] req_mode = wb_dat_i[1:0];
   wire exit_idle = mode == RSPM_IDLE && wake_irq_i;
   wire exit_pd = (mode == RSPM_PD || mode == RSPM_TPD) && pd_wake_i;
   always_ff @(posedge mclk_i) begin
      if (!nrst_i) begin
         mode <= RSPM_RUN;
      end else if (any_rst || exit_idle || exit_pd) begin
         mode <= RSPM_RUN;
      end else if (wr_mode && mode == RSPM_RUN) begin
         mode <= rspm_mode_t'(req_mode);
      end
   end

   // Mode-driven enables, registered for clean outputs
   wire deep = mode == RSPM_PD || mode == RSPM_TPD;
   wire next_rc = mode == RSPM_TPD ? 1'b0
      : (mode == RSPM_PD ? (rc_is_sysclk_i && rtc_en_i) : 1'b1);
   always_ff @(posedge mclk_i) begin
      if (!nrst_i) begin
         periph_run_o <= 1'b1;
         osc_run_o <= 1'b1;
         rc_osc_run_o <= 1'b1;
         brownout_en_o <= 1'b1;
         comp_en_o <= 1'b1;
         low_current_o <= 1'b0;
         mode_o <= RSPM_RUN;
         pin_gpio_o <= 1'b1;
      end else begin
         periph_run_o <= !deep;
         osc_run_o <= !deep;
         rc_osc_run_o <= next_rc;
         brownout_en_o <= !deep;
         comp_en_o <= mode != RSPM_TPD;
         low_current_o <= low_current_select && !deep;
         mode_o <= mode;
         pin_gpio_o <= shared_reset_pin_i;
      end
   end

   // ----------------------------------------------------------------
   // Bus read and ack
   // ----------------------------------------------------------------
   wire [31:0] rd_mux =
      wb_adr_i == RSPM_OFS_FLAGS ? {26'h0, flags} :
      wb_adr_i == RSPM_OFS_CFG ? {31'h0, reset_pin_enable} :
      wb_adr_i == RSPM_OFS_PMODE ? {30'h0, mode} :
      wb_adr_i == RSPM_OFS_REG ? {30'h0, hs_ready, low_current_select} :
      wb_adr_i == RSPM_OFS_BOOT ? {16'h0, boot_vec, 7'h00,
         boot_status_byte0} : 32'h0000_0000;
   always_ff @(posedge mclk_i) begin
      if (!nrst_i) begin
         wb_ack_o <= 1'b0;
         wb_dat_o <= 32'h0000_0000;
      end else begin
         wb_ack_o <= bus_req;
         wb_dat_o <= bus_req ? rd_mux : 32'h0000_0000;
      end
   end

   // ----------------------------------------------------------------
   // Checks
   // ----------------------------------------------------------------
   sequence wd_hit_s;
      wdog_rst_i;
   endsequence
   sequence flag_por_s;
      ##1 flags == RSPM_FLAGS_POR;
   endsequence
   wd_flags_a: assert property (
      @(posedge mclk_i) disable iff (!nrst_i)
      wd_hit_s |-> flag_por_s) else $error("watchdog flag pattern wrong");
   por_sticky_a: assert property (
      @(posedge mclk_i) disable iff (!nrst_i)
      flags[RSPM_F_POWER_ON] && !por_like && !(wr_flags
      && !wb_dat_i[RSPM_F_POWER_ON]) |=> flags[RSPM_F_POWER_ON])
      else $error("power-on flag lost");
   clr_zero_a: assert property (
      @(posedge mclk_i) disable iff (!nrst_i)
      wr_flags && !wb_dat_i[RSPM_F_SOFT] && !soft_req && !por_like
      |=> !flags[RSPM_F_SOFT]) else $error("flag not cleared");
   // A watchdog or power-on in the same cycle legally wipes the pin flag
   keep_one_a: assert property (
      @(posedge mclk_i) disable iff (!nrst_i)
      wr_flags && wb_dat_i[RSPM_F_PIN] && flags[RSPM_F_PIN] && !por_like
      |=> flags[RSPM_F_PIN]) else $error("write of one changed flag");
   warm_set_a: assert property (
      @(posedge mclk_i) disable iff (!nrst_i)
      break_rst_i && !por_like |=> flags[RSPM_F_BREAK])
      else $error("break flag not set");
   pin_gate_a: assert property (
      @(posedge mclk_i) disable iff (!nrst_i)
      !shared_reset_pin_i && reset_pin_enable |=> core_rst_o)
      else $error("pin reset ignored");
   boot_addr_a: assert property (
      @(posedge mclk_i) disable iff (!nrst_i)
      break_rst_i |=> fetch_addr_o == {$past(boot_vec), RSPM_VEC_LOW})
      else $error("boot address not used");
   tpd_gate_a: assert property (
      @(posedge mclk_i) disable iff (!nrst_i)
      mode == RSPM_TPD |=> !comp_en_o && !rc_osc_run_o && !brownout_en_o)
      else $error("total power-down gating wrong");
   idle_exit_a: assert property (
      @(posedge mclk_i) disable iff (!nrst_i)
      mode == RSPM_IDLE && wake_irq_i |=> mode == RSPM_RUN)
      else $error("idle did not exit");
   stretch_a: assert property (
      @(posedge mclk_i) disable iff (!nrst_i)
      $fell(any_rst) |=> core_rst_o [*8]) else $error("reset too short");
   // Flag pattern and regulator select after power-on, zero fetch address after non-boot resets, mode-driven enables in idle and power-down
   por_flags_a: assert property (
      @(posedge mclk_i) disable iff (!nrst_i)
      power_up_i |=> flags == RSPM_FLAGS_POR)
      else $error("power-on flag pattern wrong");
   zero_vec_a: assert property (
      @(posedge mclk_i) disable iff (!nrst_i)
      any_rst && !boot_pick |=> fetch_addr_o == RSPM_VEC_ZERO)
      else $error("fetch address not zero");
   idle_run_a: assert property (
      @(posedge mclk_i) disable iff (!nrst_i)
      mode == RSPM_IDLE |=> periph_run_o && osc_run_o)
      else $error("idle stopped peripherals");
   pd_gate_a: assert property (
      @(posedge mclk_i) disable iff (!nrst_i)
      mode == RSPM_PD |=> !osc_run_o && !brownout_en_o)
      else $error("power-down gating wrong");
   rc_stop_a: assert property (
      @(posedge mclk_i) disable iff (!nrst_i)
      mode == RSPM_PD && !(rc_is_sysclk_i && rtc_en_i) |=> !rc_osc_run_o)
      else $error("RC oscillator left running");
   hs_boot_a: assert property (
      @(posedge mclk_i) disable iff (!nrst_i)
      power_up_i |=> !low_current_select)
      else $error("low current kept after power-on");
endmodule

// file: tb/rspm_pin_model.sv
// Outside circuit on the shared reset pin, pulled up while idle.
// Assumes the bench asks for low pulses only outside power-up.
`timescale 1ns/10ps
module rspm_pin_model (
   input wire logic mclk_i,
   input wire logic hold_i,
   output logic pin_o
);
   // ------------------------------------------------------------
   // Pin driver
   // ------------------------------------------------------------
   // low on request only
   // Released pin shows the pull-up level, never a stale low
   initial pin_o = 1'b1;
   always @(posedge mclk_i) begin
      pin_o <= !hold_i;
   end
endmodule

// file: tb/rspm_top_bench.sv
// Self-checking bench for the reset source and power mode block.
// Assumes rspm_pkg, rspm_top and rspm_pin_model are compiled first.
`timescale 1ns/10ps
module rspm_top_bench;
   import rspm_pkg::*;
   logic mclk_i, nrst_i, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o;
   logic [7:0] wb_adr_i;
   logic [3:0] wb_sel_i;
   logic [31:0] wb_dat_i, wb_dat_o, rd;
   logic power_up_i, pin, brownout_i, wdog_rst_i, break_rst_i, pin_hold;
   logic prog_force_i, wake_irq_i, pd_wake_i, rc_is_sysclk_i, rtc_en_i;
   logic core_rst_o, pin_gpio_o, periph_run_o, osc_run_o, rc_osc_run_o;
   logic brownout_en_o, comp_en_o, low_current_o;
   logic [15:0] fetch_addr_o;
   rspm_mode_t mode_o;
   int err_count, samples_checked, m_flags, n;
   // Mode table: mode, sysclk+rtc, {periph,osc,rc,brownout,comp}
   logic [1:0] tm [4] = '{2'h1, 2'h2, 2'h2, 2'h3};
   logic ts [4] = '{1'b1, 1'b1, 1'b0, 1'b1};
   logic [4:0] te [4] = '{5'h1F, 5'h05, 5'h01, 5'h00};
   // ------------------------------------------------------------
   // Clock, design and partner
   // ------------------------------------------------------------
   initial begin
      mclk_i = 1'b0;
      forever #20 mclk_i = ~mclk_i;
   end
   rspm_pin_model pin_u (.mclk_i(mclk_i), .hold_i(pin_hold), .pin_o(pin));
   rspm_top dut_u (.mclk_i(mclk_i), .nrst_i(nrst_i), .wb_cyc_i(wb_cyc_i),
      .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i),
      .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o),
      .wb_ack_o(wb_ack_o), .power_up_i(power_up_i),
      .shared_reset_pin_i(pin), .brownout_i(brownout_i),
      .wdog_rst_i(wdog_rst_i), .break_rst_i(break_rst_i),
      .prog_force_i(prog_force_i), .wake_irq_i(wake_irq_i),
      .pd_wake_i(pd_wake_i), .rc_is_sysclk_i(rc_is_sysclk_i),
      .rtc_en_i(rtc_en_i), .core_rst_o(core_rst_o),
      .fetch_addr_o(fetch_addr_o), .pin_gpio_o(pin_gpio_o),
      .periph_run_o(periph_run_o), .osc_run_o(osc_run_o),
      .rc_osc_run_o(rc_osc_run_o), .brownout_en_o(brownout_en_o),
      .comp_en_o(comp_en_o), .low_current_o(low_current_o),
      .mode_o(mode_o));
   // ------------------------------------------------------------
   // Tasks
   // ------------------------------------------------------------
   task automatic chk(input string nm, input logic [31:0] e, g);
      samples_checked++;
      if (g !== e) begin
         err_count++;
         $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
      end
   endtask
   // Classic cycle; request held until ack is sampled high
   task automatic wb(input logic we, input logic [7:0] a,
      input logic [31:0] d);
      int k;
      k = 0;
      wb_cyc_i <= 1'b1;
      wb_stb_i <= 1'b1;
      wb_we_i <= we;
      wb_adr_i <= a;
      wb_dat_i <= d;
      do begin
         @(posedge mclk_i);
         k++;
      end while (wb_ack_o !== 1'b1 && k < 100);
      if (k >= 100) chk("bus ack", 1, 0);
      rd = wb_dat_o;
      wb_cyc_i <= 1'b0;
      wb_stb_i <= 1'b0;
      @(posedge mclk_i);
   endtask
   task automatic rdchk(input logic [7:0] a, input int e);
      wb(1'b0, a, 32'h0);
      chk("register read", 32'(e), rd);
   endtask
   // Wait for the core reset to rise and then to end
   task automatic wait_rst();
      int k;
      k = 0;
      while (core_rst_o !== 1'b1 && k < 20) begin
         @(posedge mclk_i);
         k++;
      end
      chk("core reset seen", 1, core_rst_o);
      while (core_rst_o !== 1'b0 && k < 200) begin
         @(posedge mclk_i);
         k++;
      end
      chk("core reset end", 0, core_rst_o);
   endtask
   // Fire one reset source, then compare the flags with the model
   task automatic fire(input int s);
      if (s == RSPM_F_SOFT) wb(1'b1, RSPM_OFS_SWRST, RSPM_SWRST_KEY);
      else begin
         brownout_i <= (s == RSPM_F_BROWNOUT);
         wdog_rst_i <= (s == RSPM_F_WDOG);
         break_rst_i <= (s == RSPM_F_BREAK);
         pin_hold <= (s == RSPM_F_PIN);
         @(posedge mclk_i);
         {brownout_i, wdog_rst_i, break_rst_i, pin_hold} <= 4'h0;
         @(posedge mclk_i);
      end
      wait_rst();
      if (s == RSPM_F_WDOG) m_flags = 6;
      else m_flags |= 1 << s;
      rdchk(RSPM_OFS_FLAGS, m_flags);
   endtask
   task automatic stop_test();
      $display("checks %0d mismatches %0d", samples_checked, err_count);
      if (err_count == 0 && samples_checked > 0) $display("Testbench passed");
      else $display("Testbench failed");
      $finish;
   endtask
   // ------------------------------------------------------------
   // Watchdog against a hung run
   // ------------------------------------------------------------
   initial begin
      #(40 * 10000);
      err_count++;
      stop_test();
   end
   // ------------------------------------------------------------
   // Main sequence
   // ------------------------------------------------------------
   initial begin
      {nrst_i, wb_cyc_i, wb_stb_i, wb_we_i, power_up_i, brownout_i} = 6'h0;
      {wdog_rst_i, break_rst_i, prog_force_i, wake_irq_i, pd_wake_i} = 5'h0;
      {rc_is_sysclk_i, rtc_en_i, pin_hold} = 3'h0;
      {wb_adr_i, wb_sel_i, wb_dat_i} = 44'h0;
      wb_sel_i = 4'hF;
      err_count = 0;
      samples_checked = 0;
      void'($urandom(32'h08dc6bcc));
      repeat (16) @(posedge mclk_i);
      nrst_i <= 1'b1;
      wait_rst();
      m_flags = 6;
      rdchk(RSPM_OFS_FLAGS, 6);
      rdchk(8'h3C, 0);
      rdchk(RSPM_OFS_REG, 2);
      chk("fetch", RSPM_VEC_ZERO, fetch_addr_o);
      $display("test reset values done");
      fire(RSPM_F_SOFT);
      chk("fetch", RSPM_VEC_ZERO, fetch_addr_o);
      fire(RSPM_F_BREAK);
      chk("fetch", {RSPM_BOOT_VEC_RST, RSPM_VEC_LOW}, fetch_addr_o);
      for (int i = 0; i < 3; i++) begin
         wb(1'b1, RSPM_OFS_FLAGS, $urandom);
         m_flags &= wb_dat_i[5:0];
         rdchk(RSPM_OFS_FLAGS, m_flags);
      end
      $display("test flag writes done");
      pin_hold <= 1'b1;
      repeat (4) @(posedge mclk_i);
      chk("pin as input", 0, core_rst_o);
      chk("pin level", 0, pin_gpio_o);
      pin_hold <= 1'b0;
      wb(1'b1, RSPM_OFS_CFG, 32'h1);
      fire(RSPM_F_PIN);
      wb(1'b1, RSPM_OFS_FLAGS, 32'h0000_0021);
      m_flags &= 32'h21;
      rdchk(RSPM_OFS_FLAGS, m_flags);
      wb(1'b1, RSPM_OFS_BOOT, 32'h1F01);
      fire(RSPM_F_SOFT);
      chk("fetch", {RSPM_BOOT_VEC_RST, RSPM_VEC_LOW}, fetch_addr_o);
      wb(1'b1, RSPM_OFS_BOOT, 32'h1F00);
      fire(RSPM_F_BROWNOUT);
      fire(RSPM_F_WDOG);
      $display("test reset sources done");
      for (int i = 0; i < 4; i++) begin
         rc_is_sysclk_i <= ts[i];
         rtc_en_i <= ts[i];
         wb(1'b1, RSPM_OFS_PMODE, {30'h0, tm[i]});
         repeat (3) @(posedge mclk_i);
         chk("mode", {30'h0, tm[i]}, {30'h0, mode_o});
         chk("enables", {27'h0, te[i]}, {27'h0, periph_run_o, osc_run_o,
            rc_osc_run_o, brownout_en_o, comp_en_o});
         brownout_i <= (tm[i] != 2'h1);
         @(posedge mclk_i);
         brownout_i <= 1'b0;
         repeat (3) @(posedge mclk_i);
         chk("brownout off", 0, core_rst_o);
         wake_irq_i <= (tm[i] == 2'h1);
         pd_wake_i <= (tm[i] != 2'h1);
         @(posedge mclk_i);
         {wake_irq_i, pd_wake_i} <= 2'h0;
         repeat (3) @(posedge mclk_i);
         chk("mode after wake", 0, {30'h0, mode_o});
      end
      $display("test power modes done");
      wb(1'b1, RSPM_OFS_REG, 32'h1);
      chk("low current", 1, low_current_o);
      rdchk(RSPM_OFS_REG, 1);
      wb(1'b1, RSPM_OFS_REG, 32'h0);
      rdchk(RSPM_OFS_REG, 0);
      n = 0;
      do begin
         wb(1'b0, RSPM_OFS_REG, 32'h0);
         n++;
      end while (rd[1] !== 1'b1 && n < 60);
      chk("ready", 2, rd);
      chk("settle wait", 1, n > 10);
      $display("test regulator done");
      power_up_i <= 1'b1;
      prog_force_i <= 1'b1;
      @(posedge mclk_i);
      power_up_i <= 1'b0;
      prog_force_i <= 1'b0;
      wait_rst();
      rdchk(RSPM_OFS_FLAGS, 6);
      chk("fetch", {RSPM_BOOT_VEC_RST, RSPM_VEC_LOW}, fetch_addr_o);
      rdchk(RSPM_OFS_REG, 2);
      $display("test power-on done");
      stop_test();
   end
endmodule
